// ===== dv/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// pin mux testbench
// ****************************************************************
module testbench;
  import pin_mux_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       watchdog_reset = 1'b0;
  logic       soft_reset = 1'b0;
  pin_cfg_t   cfg = '0;
  logic [3:0] pulse_out = 4'h0;
  logic       reset_pin_in = 1'b1;
  logic [3:0] port_a_in = 4'h0;
  logic       chip_rstn, line7, rp_out, rp_oe, rp_pu;
  pad_ctrl_t  pad;
  logic [3:0] data;
  int         err_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed = 32'h6da1;
  localparam int REL = 2;  // short release count keeps the run brief

  pin_mux #(.RELEASE_CYCLES(REL)) DUT (
    .clk(clk), .rstn(rstn), .watchdog_reset(watchdog_reset), .soft_reset(soft_reset),
    .system_integration_module(cfg), .pulse_out(pulse_out), .reset_pin_in(reset_pin_in),
    .port_a_in(port_a_in), .chip_rstn(chip_rstn), .port_a_line7_on_reset_pin(line7),
    .reset_pin_out(rp_out), .reset_pin_oe(rp_oe), .reset_pin_pull_up(rp_pu),
    .port_a_pad(pad), .port_a_data(data));

  // 50 ns clock and cycle ceiling
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      err_count++;
      $display("FAIL timeout expected 5000 seen %0d", cycles);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for the internal reset level, sampled away from the clock edge
  task automatic wait_rst(input logic level, input int lim);
    int i = 0;
    @(negedge clk);
    while (chip_rstn !== level && i < lim) begin
      @(negedge clk);
      i++;
    end
    check("chip_rstn", 32'(level), 32'(chip_rstn));
  endtask

  task automatic check_reset_pads();
    check("chip_rstn held", 32'h0, 32'(chip_rstn));
    check("pad oe", 32'h0, 32'(pad.oe));
    check("pad pull_up", 32'hf, 32'(pad.pull_up));
    check("reset pin oe", 32'h0, 32'(rp_oe));
    check("reset pin pull_up", 32'h1, 32'(rp_pu));
  endtask

  function automatic pad_ctrl_t exp_pad(input pin_cfg_t c, input logic [3:0] p);
    exp_pad.oe      = c.alt_sel | c.gpio_oe;
    exp_pad.out     = (c.alt_sel & p) | (~c.alt_sel & c.gpio_out);
    exp_pad.pull_up = 4'h0;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    pin_cfg_t   c;
    pad_ctrl_t  p;
    logic [31:0] rnd;
    logic       pin;
    wait_cyc(3);
    @(negedge clk);
    check_reset_pads();
    @(posedge clk) rstn <= 1'b1;
    @(negedge clk);
    check("chip_rstn after release", 32'h0, 32'(chip_rstn));
    wait_rst(1'b1, 40);
    wait_cyc(2);
    @(negedge clk);
    check("pad oe default", 32'h0, 32'(pad.oe));
    check("reset pin pull_up default", 32'h1, 32'(rp_pu));
    check("line7 default", 32'h1, 32'(line7));
    $display("test reset_release done");
    for (int i = 0; i < 40; i++) begin
      wait_cyc(1);
      reset_pin_in <= 1'b1;
      wait_cyc(4);
      rnd = $random(seed);
      c = rnd[13:0];
      if (i == 0) c = '{RST_FN_GPIO, 1'b1, 4'hf, 4'h0, 4'h0};
      if (i == 1) c = '{RST_FN_GPIO, 1'b0, 4'h0, 4'hf, 4'ha};
      cfg <= c;
      rnd = $random(seed);
      pulse_out <= rnd[3:0];
      port_a_in <= rnd[7:4];
      wait_cyc(4);
      pin = (c.reset_pin_fn == RST_FN_GPIO) ? rnd[8] : 1'b1;
      reset_pin_in <= pin;
      wait_cyc(5);
      @(negedge clk);
      p = exp_pad(c, pulse_out);
      check("pad oe", 32'(p.oe), 32'(pad.oe));
      check("pad out", 32'(p.out & p.oe), 32'(pad.out & p.oe));
      check("pad pull_up", 32'h0, 32'(pad.pull_up));
      check("line data", 32'(port_a_in), 32'(data));
      check("reset pin oe", 32'(c.reset_pin_fn == RST_FN_GPIO && c.line7_drive),
            32'(rp_oe));
      check("reset pin out", 32'h0, 32'(rp_out));
      check("line7 in", 32'(pin), 32'(line7));
      check("chip_rstn run", 32'h1, 32'(chip_rstn));
    end
    $display("test random_config done");
    wait_cyc(1);
    reset_pin_in <= 1'b1;
    wait_cyc(4);
    cfg <= '0;
    wait_cyc(4);
    reset_pin_in <= 1'b0;
    wait_rst(1'b0, 5);
    wait_cyc(2);
    @(negedge clk);
    check_reset_pads();
    @(posedge clk) reset_pin_in <= 1'b1;
    wait_cyc(2 + REL);
    @(negedge clk);
    check("chip_rstn release count", 32'h0, 32'(chip_rstn));
    wait_rst(1'b1, 0);
    wait_cyc(2);
    @(negedge clk);
    check("reset pin oe", 32'h0, 32'(rp_oe));
    check("reset pin pull_up", 32'h1, 32'(rp_pu));
    check("pad oe", 32'h0, 32'(pad.oe));
    $display("test reset_pin done");
    for (int k = 0; k < 2; k++) begin
      wait_cyc(1);
      cfg <= '{RST_FN_GPIO, 1'b0, 4'h0, 4'h0, 4'h0};
      reset_pin_in <= 1'b0;
      wait_cyc(5);
      @(negedge clk);
      check("chip_rstn pin ignored", 32'h1, 32'(chip_rstn));
      @(posedge clk);
      if (k == 0) watchdog_reset <= 1'b1;
      else soft_reset <= 1'b1;
      reset_pin_in <= 1'b1;
      wait_cyc(1);
      watchdog_reset <= 1'b0;
      soft_reset <= 1'b0;
      wait_rst(1'b0, 4);
      wait_rst(1'b1, 40);
    end
    $display("test other_sources done");
    stop_test();
  end
endmodule // testbench

// ===== logic/pin_mux.sv
`timescale 1ns/1ps
module pin_mux #(
  parameter int RELEASE_CYCLES = pin_mux_pkg::RST_RELEASE_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,            // power-on reset
  input  wire logic                   watchdog_reset,  // active high, same domain
  input  wire logic                   soft_reset,      // active high, same domain
  input  wire pin_mux_pkg::pin_cfg_t  system_integration_module,
  input  wire logic [3:0]             pulse_out,       // channels 0..3
  input  wire logic                   reset_pin_in,    // pad level of reset pin
  input  wire logic [3:0]             port_a_in,       // pad levels of lines 0..3
  output logic                        chip_rstn,
  output logic                        port_a_line7_on_reset_pin, // line 7 input
  output logic                        reset_pin_out,
  output logic                        reset_pin_oe,
  output logic                        reset_pin_pull_up,
  output pin_mux_pkg::pad_ctrl_t      port_a_pad,
  output logic [3:0]                  port_a_data      // lines 0..3 input values
);
  import pin_mux_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic       rp_s1;
    logic       rp_s2;
    logic [3:0] pa_s1;
    logic [3:0] pa_s2;
    logic       line7;
    logic [3:0] data;
    logic       r_out;
    logic       r_oe;
    logic       r_pu;
    pad_ctrl_t  pad;
  } mux_state_t;

  mux_state_t s;
  mux_state_t next_s;
  logic       in_reset;
  logic       pin_hold;
  logic       hold;
  logic       seq_rstn;

  // ****************************************************************
  // reset sources
  // ****************************************************************
  // reset pin counts only in its primary function
  assign pin_hold = (system_integration_module.reset_pin_fn == RST_FN_RESET)
                    && !s.rp_s2;
  assign hold     = pin_hold || watchdog_reset || soft_reset;

  reset_release #(
    .CYCLES (RELEASE_CYCLES)
  ) u_release (
    .clk       (clk),
    .rstn      (rstn),
    .hold      (hold),
    .chip_rstn (seq_rstn)
  );

  assign in_reset = !seq_rstn;

  // ****************************************************************
  // pad control
  // ****************************************************************
  always_comb begin
    next_s       = s;
    next_s.rp_s1 = reset_pin_in;
    next_s.rp_s2 = s.rp_s1;
    next_s.pa_s1 = port_a_in;
    next_s.pa_s2 = s.pa_s1;
    next_s.data  = s.pa_s2;
    if (in_reset) begin
      // all pins input with pull-up
      next_s.r_out   = 1'b0;
      next_s.r_oe    = 1'b0;
      next_s.r_pu    = 1'b1;
      next_s.line7   = 1'b1;
      next_s.pad.out = LINES_ZERO;
      next_s.pad.oe  = LINES_ZERO;
      next_s.pad.pull_up = LINES_ONES;
    end else begin
      // reset pin: only open drain low drive in gpio mode
      if (system_integration_module.reset_pin_fn == RST_FN_GPIO) begin
        next_s.r_out = 1'b0;
        next_s.r_oe  = system_integration_module.line7_drive;
        next_s.r_pu  = 1'b0;
        next_s.line7 = s.rp_s2;
      end else begin
        next_s.r_out = 1'b0;
        next_s.r_oe  = 1'b0;
        next_s.r_pu  = 1'b1;
        next_s.line7 = 1'b1;
      end
      next_s.pad.pull_up = LINES_ZERO;
      for (int i = 0; i < NUM_LINES; i++) begin
        if (system_integration_module.alt_sel[i]) begin
          next_s.pad.out[i] = pulse_out[i];
          next_s.pad.oe[i]  = 1'b1;
        end else begin
          next_s.pad.out[i] = system_integration_module.gpio_out[i];
          next_s.pad.oe[i]  = system_integration_module.gpio_oe[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{rp_s1: 1'b1, rp_s2: 1'b1, pa_s1: LINES_ZERO, pa_s2: LINES_ZERO,
             line7: 1'b1, data: LINES_ZERO, r_out: 1'b0, r_oe: 1'b0, r_pu: 1'b1,
             pad: '{out: LINES_ZERO, oe: LINES_ZERO, pull_up: LINES_ONES}};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign chip_rstn                 = seq_rstn;
  assign port_a_line7_on_reset_pin = s.line7;
  assign reset_pin_out             = s.r_out;
  assign reset_pin_oe              = s.r_oe;
  assign reset_pin_pull_up         = s.r_pu;
  assign port_a_pad                = s.pad;
  assign port_a_data               = s.data;

  // ****************************************************************
  // checks
  // ****************************************************************
  // open-drain line 7 never drives the pad high
  a_od_never_high: assert property (@(posedge clk) disable iff (!rstn)
    reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");

  // running chip stays out of reset while the pin is a plain line
  a_pin_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (system_integration_module.reset_pin_fn == RST_FN_GPIO && !watchdog_reset
     && !soft_reset && chip_rstn) |=> chip_rstn)
    else $error("reset pin used as reset source in gpio mode");

  // watchdog and software reset keep working in either pin mode
  a_other_sources: assert property (@(posedge clk) disable iff (!rstn)
    (watchdog_reset || soft_reset)
    |=> !chip_rstn)
    else $error("watchdog or software reset ignored");

  // a low reset pin in its primary function pulls the chip into reset
  a_pin_resets: assert property (@(posedge clk) disable iff (!rstn)
    (pin_hold && chip_rstn) |=> !chip_rstn)
    else $error("reset pin did not reset chip");

  // every pin is an input with pull-up while the chip is held
  a_reset_inputs: assert property (@(posedge clk) disable iff (!rstn)
    in_reset |=> (port_a_pad.oe == LINES_ZERO && !reset_pin_oe
                  && port_a_pad.pull_up == LINES_ONES))
    else $error("pins not input with pull-up in reset");

  // an unselected line only drives when its direction bit says so
  a_no_default_alt: assert property (@(posedge clk) disable iff (!rstn)
    (!system_integration_module.alt_sel[0] && !in_reset)
    |=> port_a_pad.oe[0] == $past(system_integration_module.gpio_oe[0]))
    else $error("alternate function without selection");

  // a selected line carries its pulse channel as an output
  a_pulse_route: assert property (@(posedge clk) disable iff (!rstn)
    (system_integration_module.alt_sel[1] && !in_reset)
    |=> (port_a_pad.oe[1] && port_a_pad.out[1] == $past(pulse_out[1])))
    else $error("pulse channel not routed");

  // a general purpose line drives its programmed value
  a_gpio_output: assert property (@(posedge clk) disable iff (!rstn)
    (!system_integration_module.alt_sel[2] && !in_reset)
    |=> port_a_pad.out[2] == $past(system_integration_module.gpio_out[2]))
    else $error("gpio output value wrong");

  // reset pin in its primary function is never driven
  a_reset_default: assert property (@(posedge clk) disable iff (!rstn)
    (system_integration_module.reset_pin_fn == RST_FN_RESET)
    |=> !reset_pin_oe)
    else $error("reset pin driven in reset function");

  // every line's direction follows its select and direction bits
  a_line_dirs: assert property (@(posedge clk) disable iff (!rstn)
    !in_reset
    |=> port_a_pad.oe == ($past(system_integration_module.alt_sel)
                          | $past(system_integration_module.gpio_oe)))
    else $error("line direction does not follow configuration");

  // line pull-ups drop once the chip runs
  a_pull_up_off: assert property (@(posedge clk) disable iff (!rstn)
    !in_reset
    |=> port_a_pad.pull_up == LINES_ZERO)
    else $error("line pull-up left on out of reset");

  // line 7 input shows the synchronised pad level in gpio mode
  a_line7_follow: assert property (@(posedge clk) disable iff (!rstn)
    (system_integration_module.reset_pin_fn == RST_FN_GPIO && !in_reset)
    |=> port_a_line7_on_reset_pin == $past(s.rp_s2))
    else $error("line 7 input does not follow the pad");

  // line 7 input rests high while the pin is the reset input
  a_line7_idle: assert property (@(posedge clk) disable iff (!rstn)
    (system_integration_module.reset_pin_fn == RST_FN_RESET)
    |=> port_a_line7_on_reset_pin)
    else $error("line 7 input active in reset function");

endmodule // pin_mux

// ===== logic/pin_mux_pkg.sv
package pin_mux_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int          NUM_LINES         = 4;   // port A lines 0..3
  localparam int          RST_RELEASE_CYC   = 16;  // internal clocks before release
  localparam int          CNT_W             = 5;
  localparam logic [4:0]  CNT_ZERO          = 5'h00;
  localparam logic [3:0]  LINES_ZERO        = 4'h0;
  localparam logic [3:0]  LINES_ONES        = 4'hf;

  // reset pin function select encoding
  typedef enum logic [0:0] {
    RST_FN_RESET = 1'b0,   // primary: reset input
    RST_FN_GPIO  = 1'b1    // alternate: port A line 7, open drain
  } rst_fn_t;

  // reset release sequencer states
  typedef enum logic [1:0] {
    SEQ_HOLD    = 2'b00,
    SEQ_COUNT   = 2'b01,
    SEQ_RUN     = 2'b10
  } seq_state_t;

  // software configuration of the pins
  typedef struct packed {
    rst_fn_t    reset_pin_fn;   // function of the reset pin
    logic       line7_drive;    // line 7 pulls low when set
    logic [3:0] alt_sel;        // 1: pulse channel on line n
    logic [3:0] gpio_oe;        // 1: line n is an output
    logic [3:0] gpio_out;       // output value of line n
  } pin_cfg_t;

  // pad controls for one group of pins
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] pull_up;
  } pad_ctrl_t;

endpackage

// ===== logic/reset_release.sv
`timescale 1ns/1ps
// ****************************************************************
// reset release sequencer
// ****************************************************************
module reset_release #(
  parameter int CYCLES = pin_mux_pkg::RST_RELEASE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic hold,      // reset source active (synchronised)
  output logic      chip_rstn  // internal reset, low while held
);
  import pin_mux_pkg::*;

  typedef struct packed {
    seq_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic             out_n;
  } rr_state_t;

  rr_state_t s;
  rr_state_t next_s;

  // count clocks after the source goes away, then release
  always_comb begin
    next_s = s;
    case (s.st)
      SEQ_HOLD: begin
        next_s.out_n = 1'b0;
        next_s.cnt   = CNT_ZERO;
        if (!hold) begin
          next_s.st = SEQ_COUNT;
        end
      end
      SEQ_COUNT: begin
        if (hold) begin
          next_s.st = SEQ_HOLD;
        end else if (s.cnt == CNT_W'(CYCLES - 1)) begin
          next_s.st    = SEQ_RUN;
          next_s.out_n = 1'b1;
        end else begin
          next_s.cnt = s.cnt + CNT_W'(1);
        end
      end
      SEQ_RUN: begin
        if (hold) begin
          next_s.st    = SEQ_HOLD;
          next_s.out_n = 1'b0;
        end
      end
      default: begin
        next_s.st = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: SEQ_HOLD, cnt: CNT_ZERO, out_n: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign chip_rstn = s.out_n;

  // chip stays in reset on the first count clock; release comes CYCLES + 1 clocks after hold drops
  a_release_delay: assert property (@(posedge clk) disable iff (!rstn)
    (s.st == SEQ_COUNT && s.cnt == CNT_ZERO && !hold) |-> !chip_rstn)
    else $error("internal reset released too early");

endmodule // reset_release
